// ---- logic/epc_master.sv ----
// master end: AXI4-Lite registers driving the cyclic link
`timescale 1ns/1ps
module epc_master #(
    parameter int HOLD_CYCLES    = epc_pkg::HOLD_CYC,    // strobe level hold, shortenable
    parameter int REFRESH_CYCLES = epc_pkg::REFRESH_CYC  // link refresh period
) (
    input  wire logic        aclk,      // system clock
    input  wire logic        aresetn,   // synchronous reset, active low
    input  wire logic [7:0]  awaddr,    // write address
    input  wire logic        awvalid,   // write address valid
    output logic             awready,   // write address ready
    input  wire logic [31:0] wdata,     // write data
    input  wire logic [3:0]  wstrb,     // write strobes
    input  wire logic        wvalid,    // write data valid
    output logic             wready,    // write data ready
    output logic [1:0]       bresp,     // write response
    output logic             bvalid,    // write response valid
    input  wire logic        bready,    // write response ready
    input  wire logic [7:0]  araddr,    // read address
    input  wire logic        arvalid,   // read address valid
    output logic             arready,   // read address ready
    output logic [31:0]      rdata,     // read data
    output logic [1:0]       rresp,     // read response
    output logic             rvalid,    // read data valid
    input  wire logic        rready,    // read data ready
    epc_link_if.master       link       // cyclic link
);
    import epc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,   // strobe low, waiting
        ST_HIGH = 3'b010,   // strobe held high
        ST_LOW  = 3'b100    // strobe held low before next load
    } epc_load_e;

    epc_load_e   state_r;          // strobe sequencer
    logic [31:0] hold_cnt_r;       // level hold counter
    logic [31:0] refr_cnt_r;       // refresh divider
    logic        req_r;            // load requested by software
    logic        clear_r;          // fault_clear level
    logic [31:0] value_r;          // load value
    logic [7:0]  monsel_r;         // monitor selection code
    logic        strobe_r;         // strobe level driven on the link
    logic        aw_got_r;         // address taken
    logic        w_got_r;          // data taken
    logic [7:0]  aw_addr_r;        // held write address
    logic [31:0] w_data_r;         // held write data
    logic [31:0] in_r;             // sampled station input bits
    logic [31:0] pos_r;            // sampled position
    logic [31:0] mon_r;            // sampled monitor
    logic        wr_fire;          // both halves present

    assign awready = !aw_got_r && !bvalid;
    assign wready  = !w_got_r && !bvalid;
    assign arready = !rvalid;
    assign wr_fire = aw_got_r && w_got_r;

    // write channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= 8'h0;
            w_data_r  <= 32'h0;
            bvalid    <= 1'b0;
            bresp     <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_r  <= 1'b1;
                w_data_r <= wdata;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid   <= 1'b1;
                // unmapped or read-only offsets answer slave error
                bresp    <= (aw_addr_r == REG_CTRL || aw_addr_r == REG_VALUE ||
                             aw_addr_r == REG_MONSEL) ? 2'h0 : 2'h2;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // software registers; the sequencer clears the request once it starts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_r    <= 1'b0;
            clear_r  <= 1'b0;
            value_r  <= 32'h0;
            monsel_r <= 8'h0;
        end else begin
            if (state_r == ST_IDLE && req_r && refr_cnt_r == 32'h0) begin
                req_r <= 1'b0;
            end
            if (wr_fire && aw_addr_r == REG_CTRL && wstrb_ok(w_data_r)) begin
                req_r   <= w_data_r[0] | req_r;
                clear_r <= w_data_r[1];
            end
            if (wr_fire && aw_addr_r == REG_VALUE) begin
                value_r <= w_data_r;
            end
            if (wr_fire && aw_addr_r == REG_MONSEL) begin
                monsel_r <= w_data_r[7:0];
            end
        end
    end

    // byte enables are ignored; every register is taken as a whole word
    function automatic logic wstrb_ok(input logic [31:0] d);
        wstrb_ok = 1'b1;
    endfunction : wstrb_ok

    // link refresh divider
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refr_cnt_r <= 32'h0;
        end else begin
            refr_cnt_r <= (refr_cnt_r >= 32'(REFRESH_CYCLES - 1)) ? 32'h0 : refr_cnt_r + 32'h1;
        end
    end

    // strobe sequencer: value goes out first, each level held its time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= ST_IDLE;
            strobe_r   <= 1'b0;
            hold_cnt_r <= 32'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // raise only on a refresh boundary after the value is already out
                    if (req_r && refr_cnt_r == 32'h0) begin
                        strobe_r   <= 1'b1;
                        hold_cnt_r <= 32'h0;
                        state_r    <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (hold_cnt_r >= 32'(HOLD_CYCLES - 1)) begin
                        strobe_r   <= 1'b0;
                        hold_cnt_r <= 32'h0;
                        state_r    <= ST_LOW;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + 32'h1;
                    end
                end
                ST_LOW: begin
                    if (hold_cnt_r >= 32'(HOLD_CYCLES - 1)) begin
                        state_r <= ST_IDLE;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + 32'h1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // link image: reserved bits and words are always zero
    always_comb begin
        link.out_bits                           = 32'h0;
        link.out_bits[MON_SEL_LSB +: MON_SEL_W] = monsel_r;
        link.out_bits[LOAD_BIT]                 = strobe_r;
        link.out_bits[CLEAR_BIT]                = clear_r;
    end
    assign link.word0   = value_r[15:0];
    assign link.word1   = value_r[31:16];
    assign link.word2   = 16'h0;
    assign link.word3   = 16'h0;
    assign link.refresh = (refr_cnt_r == 32'h0);

    // sample station replies at each refresh
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_r  <= 32'h0;
            pos_r <= 32'h0;
            mon_r <= 32'h0;
        end else if (refr_cnt_r == 32'h0) begin
            in_r  <= link.in_bits;
            pos_r <= link.pos_data;
            mon_r <= link.mon_data;
        end
    end

    // read channel: one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= 2'h0;
            case (araddr)
                REG_CTRL:    rdata <= {30'h0, clear_r, req_r};
                REG_VALUE:   rdata <= value_r;
                REG_MONSEL:  rdata <= {24'h0, monsel_r};
                REG_STATUS:  rdata <= {28'h0, in_r[READY_BIT], in_r[ERROR_BIT], in_r[ACK_BIT],
                                       (state_r != ST_IDLE) || req_r};
                REG_MONDATA: rdata <= mon_r;
                REG_POS:     rdata <= pos_r;
                default: begin
                    rdata <= 32'h0;
                    rresp <= 2'h2;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : epc_master

// ---- logic/epc_pkg.sv ----
// package of constants shared by both ends of the preset link
package epc_pkg;
    // remote output bit positions
    localparam int MON_SEL_LSB   = 0;              // monitor selection code low bit
    localparam int MON_SEL_W     = 8;              // monitor selection code width
    localparam int LOAD_BIT      = 8;              // position load strobe bit
    localparam int CLEAR_BIT     = 27;             // fault_clear bit
    // remote input bit positions
    localparam int ACK_BIT       = 8;              // load acknowledge input
    localparam int READY_BIT     = 27;             // ready input
    localparam int ERROR_BIT     = 26;             // error input
    // monitor selection codes
    localparam logic [7:0] MON_ERRORS  = 8'h00;    // error information
    localparam logic [7:0] MON_PRESET  = 8'h09;    // preset function selection
    localparam logic [7:0] MON_SCALING = 8'h0c;    // scaling data
    // error information bit positions
    localparam int ERR_SENSOR    = 0;              // sensor error
    localparam int ERR_MEMORY    = 1;              // memory error
    localparam int ERR_HARDWARE  = 2;              // hardware error
    localparam int ERR_SETTING   = 6;              // setting alarm
    // timing
    localparam int CLK_HZ        = 25000000;       // aclk rate
    localparam int HOLD_MS       = 100;            // least level hold of the strobe
    localparam int HOLD_CYC      = CLK_HZ / 1000 * HOLD_MS;   // cycles per strobe level
    localparam int PROC_MS       = 10;             // longest internal processing time
    localparam int PROC_CYC      = CLK_HZ / 1000 * PROC_MS;   // cycles of processing
    localparam int REFRESH_CYC   = 1000;           // link refresh period in cycles
    // reset values
    localparam logic [31:0] SCALE_RST = 32'h2249ffff + 32'h1; // factory scaling data
    // controller register offsets (AXI4-Lite byte addresses)
    localparam logic [7:0] REG_CTRL    = 8'h00;    // bit0 load request, bit1 clear request
    localparam logic [7:0] REG_VALUE   = 8'h04;    // load value to send
    localparam logic [7:0] REG_MONSEL  = 8'h08;    // monitor selection code
    localparam logic [7:0] REG_STATUS  = 8'h0c;    // bit0 busy, bit1 ack, bit2 error, bit3 ready
    localparam logic [7:0] REG_MONDATA = 8'h10;    // monitor data returned
    localparam logic [7:0] REG_POS     = 8'h14;    // position data returned
endpackage : epc_pkg

// ---- logic/epc_link_if.sv ----
// cyclic link between the master controller and the encoder station
`timescale 1ns/1ps
interface epc_link_if;
    logic        refresh;      // one-cycle link refresh pulse, from the master
    logic [31:0] out_bits;     // master output bits
    logic [15:0] word0;        // load value low half
    logic [15:0] word1;        // load value high half
    logic [15:0] word2;        // reserved word
    logic [15:0] word3;        // reserved word
    logic [31:0] in_bits;      // station input bits
    logic [31:0] pos_data;     // station position word
    logic [31:0] mon_data;     // station monitor word
    modport station (input refresh, out_bits, word0, word1, word2, word3,
                     output in_bits, pos_data, mon_data);
    modport master  (output refresh, out_bits, word0, word1, word2, word3,
                     input in_bits, pos_data, mon_data);
endinterface : epc_link_if

// ---- logic/epc_station.sv ----
// encoder station end: position counter, preset, errors and monitor
// Behaviour
// - low eight output bits select monitor item
// - load strobe replaces position with load value
// - load only on strobe rising edge
// - master holds each strobe level 100 ms
// - master avoids single-scan strobe pulses
// - clear drops error, release raises ready
// - error stays while its cause persists
// - master writes zero to reserved bits
// - load value low word then high word
// - master keeps load value below scaling (the master does not check it and sends any value)
// - load completes within 10 ms
// - master writes value before raising strobe
// - out-of-range load raises alarm, ack, error
// - valid later load clears setting alarm
// - not ready ignores strobes, ack low
// - master keeps value and strobe coherent
// - monitor word shows selected status item
// - position wraps at zero and maximum
`timescale 1ns/1ps
module epc_station #(
    // simulation may shorten the processing delay
    parameter int PROC_CYCLES = epc_pkg::PROC_CYC  // processing delay, shortenable
) (
    input  wire logic        aclk,          // system clock
    input  wire logic        aresetn,       // synchronous reset, active low
    epc_link_if.station      link,          // cyclic link
    // configuration and sensor side
    input  wire logic [31:0] scaling,       // configured scaling data
    input  wire logic        preset_en,     // preset function configured valid
    input  wire logic [2:0]  fault_cause,   // sensor, memory, hardware causes
    input  wire logic        move_up,       // one-cycle count up pulse
    input  wire logic        move_down      // one-cycle count down pulse
);
    import epc_pkg::*;

    // master state is taken on refresh pulses only
    // not on the levels that stand between them

    // link image kept between refreshes
    logic [31:0] out_r;            // output bits held from last refresh
    logic        strobe_prev_r;    // strobe seen at previous refresh
    logic        clear_prev_r;     // fault_clear at previous refresh

    // load sequence
    logic        pending_r;        // load in progress
    logic [31:0] proc_cnt_r;       // processing delay counter
    logic [31:0] load_r;           // load value captured at the edge
    logic [31:0] pos_r;            // position counter

    // status toward the master
    logic        ack_r;            // load acknowledge
    logic        alarm_r;          // setting alarm
    logic [2:0]  fault_r;          // latched hardware faults
    logic        ready_r;          // ready flag
    logic [31:0] mon_r;            // monitor word

    // decoded events
    logic        strobe_rise;      // accepted rising edge
    logic        clear_now;        // fault_clear held high

    // clear acts on the level from the last refresh
    assign clear_now   = out_r[CLEAR_BIT];
    // edges are taken only at refresh, against the value kept from the last one
    assign strobe_rise = link.refresh && link.out_bits[LOAD_BIT] && !strobe_prev_r;

    // sample the link image at each refresh
    // a torn load value is not caught here;
    // the master keeps value and strobe coherent
    // clear_prev_r mirrors the clear level seen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // nothing seen yet: strobe and clear low
            out_r         <= 32'h0;
            strobe_prev_r <= 1'b0;
            clear_prev_r  <= 1'b0;
        end else if (link.refresh) begin
            out_r         <= link.out_bits;
            strobe_prev_r <= link.out_bits[LOAD_BIT];
            clear_prev_r  <= link.out_bits[CLEAR_BIT];
        end
    end

    // load sequence: capture on edge, apply after the processing delay
    // a rise during a pending load is dropped;
    // the master's level hold rules that out
    // the value is taken whole at the edge
    // the counter restarts at every accepted edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_r  <= 1'b0;
            proc_cnt_r <= 32'h0;
            load_r     <= 32'h0;
        end else if (strobe_rise && preset_en && ready_r && !pending_r) begin
            pending_r  <= 1'b1;
            proc_cnt_r <= 32'h0;
            load_r     <= {link.word1, link.word0};
        end else if (pending_r) begin
            // finish within the processing bound
            if (proc_cnt_r >= 32'(PROC_CYCLES - 1)) begin
                pending_r <= 1'b0;
            end else begin
                proc_cnt_r <= proc_cnt_r + 32'h1;
            end
        end
    end

    // position counter, loaded or moved, wrapping at both ends
    // a load beats a move in the same cycle;
    // that cycle's move is lost, never the preset
    // both moves at once cancel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_r <= 32'h0;
        end else if (pending_r && proc_cnt_r >= 32'(PROC_CYCLES - 1) && load_r < scaling) begin
            pos_r <= load_r;
        end else if (move_up && !move_down) begin
            pos_r <= (pos_r >= scaling - 32'h1) ? 32'h0 : pos_r + 32'h1;
        end else if (move_down && !move_up) begin
            pos_r <= (pos_r == 32'h0) ? scaling - 32'h1 : pos_r - 32'h1;
        end
    end

    // acknowledge follows the strobe level once a load is done
    // it rises for in-range and out-of-range loads
    // and falls once a refresh shows the strobe low
    // a steady high strobe loads only once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_r <= 1'b0;
        end else if (!preset_en || !ready_r) begin
            // disabled or faulted: no answer
            ack_r <= 1'b0;
        end else if (pending_r && proc_cnt_r >= 32'(PROC_CYCLES - 1)) begin
            ack_r <= 1'b1;
        end else if (!out_r[LOAD_BIT]) begin
            ack_r <= 1'b0;
        end
    end

    // setting alarm: out-of-range raises, good load clears
    // fault_clear does not drop the alarm;
    // only a later good load does
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_r <= 1'b0;
        end else if (pending_r && proc_cnt_r >= 32'(PROC_CYCLES - 1)) begin
            alarm_r <= (load_r >= scaling);
        end
    end

    // hardware faults: set wins over clear; cause keeps them latched
    // a cause still present re-latches at once,
    // so a clear can not hide it
    // ready rises only after clear is released
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_r <= 3'h0;
            ready_r <= 1'b1;
        end else begin
            if (clear_now) begin
                // keep only causes still present
                fault_r <= fault_cause;
            end else begin
                fault_r <= fault_r | fault_cause;
            end
            // ready returns only when clear goes back to 0 and nothing remains
            if (|fault_cause || (|fault_r && !clear_now)) begin
                ready_r <= 1'b0;
            end else if (!clear_now && clear_prev_r == 1'b0 && fault_r == 3'h0) begin
                ready_r <= 1'b1;
            end
        end
    end

    // monitor word chosen by the selection code
    // unknown codes read zero, not stale data
    // registered so the master samples a settled word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_r <= 32'h0;
        end else begin
            case (out_r[MON_SEL_LSB +: MON_SEL_W])
                MON_ERRORS:  mon_r <= {25'h0, alarm_r, 3'h0, fault_r[2], fault_r[1], fault_r[0]};
                MON_PRESET:  mon_r <= {31'h0, preset_en};
                MON_SCALING: mon_r <= scaling;
                default:     mon_r <= 32'h0;
            endcase
        end
    end

    // station inputs toward the master
    // unused input bits always read zero
    // bit positions are fixed by the package
    always_comb begin
        link.in_bits            = 32'h0;
        link.in_bits[ACK_BIT]   = ack_r;
        link.in_bits[ERROR_BIT] = alarm_r || (|fault_r);
        link.in_bits[READY_BIT] = ready_r;
    end

    // position and monitor come from flip-flops
    assign link.pos_data = pos_r;
    assign link.mon_data = mon_r;
endmodule : epc_station

// ---- sim/epc_link_sva.sv ----
// checker of the cyclic link between master end and station end
`timescale 1ns/1ps
module epc_link_sva
    import epc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        refresh,
    input wire logic [31:0] out_bits,
    input wire logic [15:0] word0,
    input wire logic [15:0] word1,
    input wire logic [15:0] word2,
    input wire logic [15:0] word3,
    input wire logic [31:0] in_bits
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire strobe = out_bits[LOAD_BIT];   // load strobe on the wire
    wire ack    = in_bits[ACK_BIT];     // load acknowledge back
    // only the code, strobe and clear bits may ever be nonzero
    reserved_zero_a: assert property ((out_bits & 32'hf7ff_fe00) == 0 && word2 == 0 && word3 == 0)
        else $error("reserved link bits not zero");
    // the bench holds each level 16 cycles; 8 is the floor checked
    hold_high_a: assert property ($rose(strobe) |-> strobe [*8])
        else $error("strobe high level too short");
    hold_low_a: assert property ($fell(strobe) |-> !strobe [*8])
        else $error("strobe low level too short");
    strobe_refresh_a: assert property ($rose(strobe) |-> $past(refresh))
        else $error("strobe rose off a refresh cycle");
    value_first_a: assert property ($rose(strobe) |-> $stable({word1, word0}))
        else $error("load value changed with the strobe");
    ack_on_strobe_a: assert property ($rose(ack) |-> strobe)
        else $error("ack rose without strobe high");
    ack_drop_low_a: assert property ($fell(ack) |-> !strobe)
        else $error("ack fell while strobe high");
    refresh_period_a: assert property (refresh |=> !refresh [*3] ##1 refresh)
        else $error("refresh period not 4 cycles");
    no_ack_unready_a: assert property (!in_bits[READY_BIT] |-> !$rose(ack))
        else $error("ack rose while not ready");
    cov_ack: cover property ($rose(ack));
    cov_error: cover property ($rose(in_bits[ERROR_BIT]));
    cov_clear: cover property ($fell(out_bits[CLEAR_BIT]));
endmodule : epc_link_sva

// ---- sim/encoder_preset_control_tb.sv ----
// self-checking bench: master end driven over AXI4-Lite, station end through its direct inputs
`timescale 1ns/1ps
module encoder_preset_control_tb;
    import epc_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rv, scaling;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rr;
    logic [2:0]  fault_cause;
    logic        preset_en, move_up, move_down, acked;
    int          errors, samples_checked;
    logic [7:0]  codes [3] = '{MON_ERRORS, MON_PRESET, MON_SCALING};
    logic [31:0] mexp [3]  = '{32'h0, 32'h1, 32'h100};
    epc_link_if lnk ();
    epc_master #(.HOLD_CYCLES(16), .REFRESH_CYCLES(4)) i_epc_master (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .link(lnk));
    epc_station #(.PROC_CYCLES(4)) i_epc_station (.aclk(aclk), .aresetn(aresetn), .link(lnk),
        .scaling(scaling), .preset_en(preset_en), .fault_cause(fault_cause), .move_up(move_up),
        .move_down(move_down));
    epc_link_sva i_epc_link_sva (.aclk(aclk), .aresetn(aresetn), .refresh(lnk.refresh),
        .out_bits(lnk.out_bits), .word0(lnk.word0), .word1(lnk.word1), .word2(lnk.word2),
        .word3(lnk.word3), .in_bits(lnk.in_bits));
    // 25 MHz clock
    initial begin
        aclk = 0;
        forever #20 aclk = ~aclk;
    end
    // remember any acknowledge, it falls once a refresh shows the strobe low
    always @(posedge aclk) begin
        if (lnk.in_bits[ACK_BIT] === 1'b1) acked <= 1'b1;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // ready is sampled mid-cycle; inputs only move at rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(negedge aclk);
            ha = awvalid && awready; hw = wvalid && wready; hb = bvalid; rr = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
        end while (hb !== 1'b1);
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ha, hr;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(negedge aclk);
            ha = arvalid && arready; hr = rvalid; rv = rdata; rr = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 0;
        end while (hr !== 1'b1);
        rready <= 0;
    endtask : rd
    // a full load: value, request, then both strobe levels and a refresh
    task automatic ld(input logic [31:0] v);
        wr(REG_VALUE, v);
        acked = 0;
        wr(REG_CTRL, 32'h1);
        repeat (40) @(posedge aclk);
    endtask : ld
    task automatic pulse(input logic up);
        @(posedge aclk);
        if (up) move_up <= 1; else move_down <= 1;
        @(posedge aclk);
        move_up <= 0; move_down <= 0;
        repeat (4) @(posedge aclk);
    endtask : pulse
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // watchdog well beyond the expected few hundred cycles
    initial begin
        #800000;
        errors++;
        end_sim();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, move_up, move_down, acked} = '0;
        {awaddr, araddr, wdata, wstrb, fault_cause} = '0;
        scaling = 32'h100; preset_en = 1; errors = 0; samples_checked = 0; aresetn = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(REG_STATUS); chk("status", 32'h8, rv);
        rd(8'h20); chk("rresp", 2'd2, rr);
        wr(REG_STATUS, 0); chk("bresp", 2'd2, rr);
        for (int i = 0; i < 3; i++) begin
            wr(REG_MONSEL, codes[i]);
            repeat (20) @(posedge aclk);
            chk("code", codes[i], lnk.out_bits[7:0]);
            rd(REG_MONDATA); chk("mon", mexp[i], rv);
        end
        ld(32'hff); chk("ack", 1, acked);
        rd(REG_POS); chk("pos", 32'hff, rv);
        pulse(1); rd(REG_POS); chk("wrap up", 0, rv);
        pulse(0); rd(REG_POS); chk("wrap down", 32'hff, rv);
        wr(REG_MONSEL, MON_ERRORS);
        ld(32'h1234_0056); chk("ack", 1, acked);
        chk("low", 16'h0056, lnk.word0);
        chk("high", 16'h1234, lnk.word1);
        rd(REG_POS); chk("pos", 32'hff, rv);
        rd(REG_STATUS); chk("error", 1, rv[2]);
        rd(REG_MONDATA); chk("alarm", 32'h40, rv);
        ld(32'h10); rd(REG_STATUS); chk("error", 0, rv[2]);
        rd(REG_POS); chk("pos", 32'h10, rv);
        preset_en <= 0;
        ld(32'h20); chk("ack", 0, acked);
        rd(REG_POS); chk("pos", 32'h10, rv);
        preset_en <= 1;
        fault_cause <= 3'h1;
        ld(32'h30); chk("ack", 0, acked);
        rd(REG_STATUS); chk("ready", 0, rv[3]);
        wr(REG_CTRL, 32'h2); repeat (20) @(posedge aclk);
        rd(REG_STATUS); chk("error", 1, rv[2]);
        fault_cause <= 3'h0;
        wr(REG_CTRL, 32'h0); wr(REG_CTRL, 32'h2); repeat (20) @(posedge aclk);
        rd(REG_STATUS); chk("error", 0, rv[2]);
        wr(REG_CTRL, 32'h0); repeat (20) @(posedge aclk);
        rd(REG_STATUS); chk("ready", 1, rv[3]);
        end_sim();
    end
endmodule : encoder_preset_control_tb
